// ---- lldma_engine.sv ----
// Linked-list DMA engine with a transmit and a receive chain
`timescale 1ns/1ps
module lldma_engine
  import lldma_pkg::*;
#(
  parameter int WIN_LIMIT = WIN_BYTES
) (
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 half_duplex,
  input  wire logic                 tx_chain_go_set,
  input  wire logic                 rx_chain_go_set,
  input  wire logic [HEAD_BITS-1:0] tx_chain_head_pointer,
  input  wire logic [HEAD_BITS-1:0] rx_chain_head_pointer,
  output logic                      tx_chain_go,
  output logic                      rx_chain_go,
  output logic                      tx_busy,
  output logic                      rx_busy,
  output logic                      tx_done,
  output logic                      rx_done,
  output logic                      desc_err,
  output logic                      bus_req,
  output logic                      bus_we,
  output logic                      bus_burst4,
  output logic [HEAD_BITS-1:0]      bus_addr,
  output logic [31:0]               bus_wdata,
  output logic [3:0]                bus_be,
  input  wire logic                 bus_ack,
  input  wire logic [31:0]          bus_rdata,
  output logic [7:0]                tx_byte,
  output logic                      tx_valid,
  output logic                      tx_eof,
  input  wire logic                 tx_ready,
  input  wire logic [7:0]           rx_byte,
  input  wire logic                 rx_valid,
  input  wire logic                 rx_last,
  output logic                      rx_ready
);

  // ==========================================================
  // Elaboration check
  if (WIN_LIMIT > (1 << HEAD_BITS) || WIN_LIMIT < 64) begin : g_chk
    $error("lldma_engine window does not fit the pointer width");
  end

  localparam logic [20:0] WIN = 21'(WIN_LIMIT);

  // ==========================================================
  // Helpers
  function automatic logic [11:0] eff_len_of(input logic [31:0] w);
    logic [11:0] l;
    logic [11:0] s;
    l = w[CW_LEN_HI:CW_LEN_LO];
    s = w[CW_SIZE_HI:CW_SIZE_LO];
    return (l < s) ? l : s;
  endfunction

  function automatic logic [2:0] words_of(input logic [4:0] b);
    logic [5:0] t;
    t = {1'b0, b} + 6'h03;
    return t[4:2];
  endfunction

  // ==========================================================
  // Channel state
  lldma_st_t      st_ff    [NCH];
  logic [19:0]    dsc_ff   [NCH];
  logic [19:0]    bptr_ff  [NCH];
  logic [19:0]    link_ff  [NCH];
  logic [31:0]    cw_ff    [NCH];
  logic [11:0]    cnt_ff   [NCH];
  logic [4:0]     bi_ff    [NCH];
  logic [4:0]     chunk_ff [NCH];
  logic [31:0]    wbuf_ff  [NCH][BURST_BEATS];
  logic [7:0]     sb_ff;
  logic           se_ff;
  logic [NCH-1:0] sv_ff;
  logic [NCH-1:0] go_ff;
  logic [NCH-1:0] busy_ff;
  logic [NCH-1:0] done_ff;
  logic [NCH-1:0] rxl_ff;
  logic           err_ff;

  // Shared bus engine state
  logic        bus_req_ff;
  logic        bus_we_ff;
  logic        bus_burst4_ff;
  logic [19:0] bus_addr_ff;
  logic [31:0] bus_wdata_ff;
  logic [3:0]  bus_be_ff;
  logic [3:0]  lbe_ff;
  logic [2:0]  beat_ff;
  logic [2:0]  nbeat_ff;
  logic        sel_ff;

  // Per-channel decode
  logic [NCH-1:0] go_set;
  logic [NCH-1:0] peer;
  logic [NCH-1:0] start;
  logic [NCH-1:0] fin_c;
  logic [NCH-1:0] bad;
  logic [NCH-1:0] step;
  logic [NCH-1:0] room;
  logic [NCH-1:0] nrxl;
  logic [NCH-1:0] cmd_req;
  logic [NCH-1:0] cmd_we;
  logic [19:0]    cmd_addr [NCH];
  logic [2:0]     cmd_n    [NCH];
  logic [3:0]     cmd_lbe  [NCH];
  logic [31:0]    cmd_w0   [NCH];
  logic [11:0]    eff_len  [NCH];
  logic [11:0]    ncnt     [NCH];
  logic [4:0]     nb       [NCH];
  logic [4:0]     tx_chunk;
  logic [11:0]    tx_rem;
  logic           bus_fin;
  logic           load;
  logic           gnt_v;
  logic           gnt_idx;

  assign go_set = {rx_chain_go_set, tx_chain_go_set};
  assign peer   = {rx_valid, tx_ready};
  // Last beat of the running bus command
  assign bus_fin = bus_req_ff && bus_ack && (beat_ff == nbeat_ff - 3'h1);
  assign load    = !bus_req_ff && gnt_v;
  assign tx_rem  = eff_len[CH_TX] - cnt_ff[CH_TX];
  assign tx_chunk = (tx_rem >= 12'(CHUNK_BYTES)) ? 5'h10 : tx_rem[4:0];

  // ==========================================================
  // Channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam bit IS_TX = (c == CH_TX);
    localparam int OTH   = 1 - c;
    logic [31:0] w0;
    logic [20:0] bend;
    assign w0   = wbuf_ff[c][0];
    assign bend = {1'b0, wbuf_ff[c][1][19:0]}
                + {9'h000, w0[CW_SIZE_HI:CW_SIZE_LO]};
    // Ownership, window and link checks on a fetched descriptor
    assign bad[c] = !w0[CW_OWNER_BIT]
                  || (wbuf_ff[c][1][31:20] != 12'h000)
                  || (bend > WIN)
                  || (!w0[CW_EOF_BIT]
                      && ({1'b0, wbuf_ff[c][2][19:0]} >= WIN));
    // Half-duplex holds one direction while the other runs
    assign start[c] = (st_ff[c] == ST_IDLE) && go_ff[c]
                    && !(half_duplex && ((st_ff[OTH] != ST_IDLE)
                    || (!IS_TX && go_ff[OTH])));
    assign fin_c[c]   = bus_fin && (sel_ff == 1'(c));
    assign eff_len[c] = eff_len_of(cw_ff[c]);
    // One byte per step: transmit load or receive take
    assign step[c] = (st_ff[c] == ST_STREAM) && (IS_TX
                   ? ((!sv_ff[c] || peer[c]) && bi_ff[c] < chunk_ff[c])
                   : (sv_ff[c] && peer[c]));
    assign nb[c]   = bi_ff[c] + {4'h0, step[c]};
    assign ncnt[c] = cnt_ff[c] + {11'h000, step[c]};
    assign nrxl[c] = rxl_ff[c] || (step[c] && rx_last);
    assign room[c] = (nb[c] < 5'h10) && !nrxl[c]
                   && (ncnt[c] < cw_ff[c][CW_SIZE_HI:CW_SIZE_LO]);
    // Bus command of this channel
    assign cmd_req[c] = (st_ff[c] == ST_FETCH) || (st_ff[c] == ST_MOVE)
                      || (st_ff[c] == ST_WBACK);
    assign cmd_we[c]  = (st_ff[c] == ST_WBACK)
                      || (!IS_TX && st_ff[c] == ST_MOVE);
    assign cmd_addr[c] = (st_ff[c] != ST_MOVE) ? dsc_ff[c]
                       : IS_TX ? bptr_ff[c] + {8'h00, cnt_ff[c]}
                       : bptr_ff[c] + {8'h00, cnt_ff[c]}
                         - {15'h0000, bi_ff[c]};
    assign cmd_n[c] = (st_ff[c] == ST_FETCH) ? 3'(DESC_WORDS)
                    : (st_ff[c] == ST_WBACK) ? 3'h1
                    : words_of(IS_TX ? tx_chunk : bi_ff[c]);
    // Partial last word keeps the unused tail unwritten
    assign cmd_lbe[c] = (st_ff[c] != ST_MOVE || IS_TX) ? BE_ALL
                      : (bi_ff[c][1:0] == 2'h1) ? 4'h1
                      : (bi_ff[c][1:0] == 2'h2) ? 4'h3
                      : (bi_ff[c][1:0] == 2'h3) ? 4'h7 : BE_ALL;
    // Write-back: owner cleared, reserved zero, real byte count
    assign cmd_w0[c] = (st_ff[c] == ST_WBACK)
                     ? {1'b0, cw_ff[c][CW_EOF_BIT], 6'h00,
                        cnt_ff[c], cw_ff[c][CW_SIZE_HI:CW_SIZE_LO]}
                     : wbuf_ff[c][0];

    // Chain walker
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        st_ff[c]    <= ST_IDLE;
        dsc_ff[c]   <= NEXT_NULL;
        bptr_ff[c]  <= NEXT_NULL;
        link_ff[c]  <= NEXT_NULL;
        cw_ff[c]    <= '0;
        cnt_ff[c]   <= CNT_RST;
        bi_ff[c]    <= '0;
        chunk_ff[c] <= '0;
        go_ff[c]    <= 1'b0;
        busy_ff[c]  <= 1'b0;
        done_ff[c]  <= 1'b0;
        rxl_ff[c]   <= 1'b0;
        sv_ff[c]    <= 1'b0;
      end else begin
        done_ff[c] <= 1'b0;
        // A new set wins over the self-clear
        if (go_set[c]) begin
          go_ff[c] <= 1'b1;
        end else if (start[c]) begin
          go_ff[c] <= 1'b0;
        end
        case (st_ff[c])
          ST_IDLE: begin
            if (start[c]) begin
              dsc_ff[c]  <= c ? rx_chain_head_pointer
                              : tx_chain_head_pointer;
              busy_ff[c] <= 1'b1;
              st_ff[c]   <= ST_FETCH;
            end
          end
          ST_FETCH: begin
            if (fin_c[c]) st_ff[c] <= ST_CHECK;
          end
          ST_CHECK: begin
            cw_ff[c]   <= w0;
            bptr_ff[c] <= wbuf_ff[c][1][19:0];
            link_ff[c] <= wbuf_ff[c][2][19:0];
            cnt_ff[c]  <= CNT_RST;
            bi_ff[c]   <= '0;
            rxl_ff[c]  <= 1'b0;
            if (bad[c]) begin
              busy_ff[c] <= 1'b0;
              done_ff[c] <= 1'b1;
              st_ff[c]   <= ST_IDLE;
            end else if (IS_TX) begin
              st_ff[c] <= (eff_len_of(w0) == CNT_RST) ? ST_WBACK : ST_MOVE;
            end else if (w0[CW_SIZE_HI:CW_SIZE_LO] == CNT_RST) begin
              st_ff[c] <= ST_WBACK;
            end else begin
              sv_ff[c] <= 1'b1;
              st_ff[c] <= ST_STREAM;
            end
          end
          ST_MOVE: begin
            if (fin_c[c]) begin
              bi_ff[c] <= '0;
              if (IS_TX) begin
                chunk_ff[c] <= tx_chunk;
                st_ff[c]    <= ST_STREAM;
              end else if (rxl_ff[c] || cnt_ff[c]
                           == cw_ff[c][CW_SIZE_HI:CW_SIZE_LO]) begin
                st_ff[c] <= ST_WBACK;
              end else begin
                sv_ff[c] <= 1'b1;
                st_ff[c] <= ST_STREAM;
              end
            end
          end
          ST_STREAM: begin
            cnt_ff[c] <= ncnt[c];
            bi_ff[c]  <= nb[c];
            if (IS_TX) begin
              // Transmit bytes handed to the peripheral
              if (step[c]) begin
                sv_ff[c] <= 1'b1;
              end else if (!sv_ff[c] || peer[c]) begin
                sv_ff[c] <= 1'b0;
                st_ff[c] <= (cnt_ff[c] == eff_len[c]) ? ST_WBACK : ST_MOVE;
              end
            end else begin
              // Receive until chunk full, buffer full or packet end
              rxl_ff[c] <= nrxl[c];
              sv_ff[c]  <= room[c];
              if (!room[c]) begin
                st_ff[c] <= (nb[c] != 5'h00) ? ST_MOVE : ST_WBACK;
              end
            end
          end
          ST_WBACK: begin
            if (fin_c[c]) begin
              if (cw_ff[c][CW_EOF_BIT] || link_ff[c] == NEXT_NULL) begin
                busy_ff[c] <= 1'b0;
                done_ff[c] <= 1'b1;
                st_ff[c]   <= ST_IDLE;
              end else begin
                dsc_ff[c] <= link_ff[c];
                st_ff[c]  <= ST_FETCH;
              end
            end
          end
          default: st_ff[c] <= ST_IDLE;
        endcase
      end
    end

    // Word buffer: bus read beats and received bytes
    always_ff @(posedge core_clk) begin
      if (bus_req_ff && bus_ack && !bus_we_ff && sel_ff == 1'(c)) begin
        wbuf_ff[c][beat_ff[1:0]] <= bus_rdata;
      end else if (!IS_TX && step[c]) begin
        wbuf_ff[c][bi_ff[c][3:2]][{bi_ff[c][1:0], 3'h0} +: 8] <= rx_byte;
      end
    end
  end

  // ==========================================================
  // Transmit byte register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sb_ff <= 8'h00;
      se_ff <= 1'b0;
    end else if (step[CH_TX]) begin
      sb_ff <= wbuf_ff[CH_TX][bi_ff[CH_TX][3:2]]
               [{bi_ff[CH_TX][1:0], 3'h0} +: 8];
      se_ff <= cw_ff[CH_TX][CW_EOF_BIT]
               && (ncnt[CH_TX] == eff_len[CH_TX]);
    end
  end

  // Sticky descriptor error, cleared by a new start request
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_ff <= 1'b0;
    end else if ((st_ff[0] == ST_CHECK && bad[0])
                 || (st_ff[1] == ST_CHECK && bad[1])) begin
      err_ff <= 1'b1;
    end else if (|go_set) begin
      err_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Bus master shared by the transmit and receive channels
  lldma_arb #(
    .N (NCH)
  ) u_arb (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .req      (cmd_req),
    .load     (load),
    .gnt_v    (gnt_v),
    .gnt_idx  (gnt_idx)
  );

  // Beat sequencer, one aligned word per beat
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_req_ff    <= 1'b0;
      bus_we_ff     <= 1'b0;
      bus_burst4_ff <= 1'b0;
      bus_addr_ff   <= NEXT_NULL;
      bus_wdata_ff  <= '0;
      bus_be_ff     <= 4'h0;
      lbe_ff        <= 4'h0;
      beat_ff       <= 3'h0;
      nbeat_ff      <= 3'h1;
      sel_ff        <= 1'b0;
    end else if (load) begin
      bus_req_ff    <= 1'b1;
      sel_ff        <= gnt_idx;
      bus_we_ff     <= cmd_we[gnt_idx];
      bus_addr_ff   <= cmd_addr[gnt_idx];
      nbeat_ff      <= cmd_n[gnt_idx];
      bus_burst4_ff <= (cmd_n[gnt_idx] == 3'(BURST_BEATS));
      bus_wdata_ff  <= cmd_w0[gnt_idx];
      lbe_ff        <= cmd_lbe[gnt_idx];
      bus_be_ff     <= (cmd_n[gnt_idx] == 3'h1) ? cmd_lbe[gnt_idx] : BE_ALL;
      beat_ff       <= 3'h0;
    end else if (bus_req_ff && bus_ack) begin
      if (bus_fin) begin
        bus_req_ff <= 1'b0;
      end else begin
        beat_ff      <= beat_ff + 3'h1;
        bus_addr_ff  <= bus_addr_ff + 20'h0_0004;
        bus_wdata_ff <= wbuf_ff[sel_ff][beat_ff[1:0] + 2'h1];
        bus_be_ff    <= (beat_ff + 3'h2 == nbeat_ff) ? lbe_ff : BE_ALL;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign tx_chain_go = go_ff[CH_TX];
  assign rx_chain_go = go_ff[CH_RX];
  assign tx_busy     = busy_ff[CH_TX];
  assign rx_busy     = busy_ff[CH_RX];
  assign tx_done     = done_ff[CH_TX];
  assign rx_done     = done_ff[CH_RX];
  assign desc_err    = err_ff;
  assign bus_req     = bus_req_ff;
  assign bus_we      = bus_we_ff;
  assign bus_burst4  = bus_burst4_ff;
  assign bus_addr    = bus_addr_ff;
  assign bus_wdata   = bus_wdata_ff;
  assign bus_be      = bus_be_ff;
  assign tx_byte     = sb_ff;
  assign tx_valid    = sv_ff[CH_TX];
  assign tx_eof      = se_ff;
  assign rx_ready    = sv_ff[CH_RX];

  // ==========================================================
  // Assertions
  go_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    start[CH_TX] && !tx_chain_go_set |=> !go_ff[CH_TX])
    else $error("start bit not cleared after chain start");
  burst_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(bus_req_ff) && bus_burst4_ff |-> bus_req_ff [*4])
    else $error("burst request dropped before four beats");
  window_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus_req_ff |-> {1'b0, bus_addr_ff} < WIN)
    else $error("bus address outside the window");
  wback_word_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus_req_ff && bus_we_ff && st_ff[sel_ff] == ST_WBACK
    |-> !bus_wdata_ff[31] && bus_wdata_ff[23:12] == cnt_ff[sel_ff])
    else $error("write-back word wrong");
  tx_count_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_ff[CH_TX] == ST_STREAM |-> cnt_ff[CH_TX] <= eff_len[CH_TX])
    else $error("transmit count passed the length");
  rx_room_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    rx_ready |-> cnt_ff[CH_RX] < cw_ff[CH_RX][CW_SIZE_HI:CW_SIZE_LO])
    else $error("receive ready with buffer full");
  rx_tail_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    bus_req_ff && bus_we_ff && sel_ff && st_ff[CH_RX] == ST_MOVE
    |-> bus_addr_ff < bptr_ff[CH_RX] + {8'h00, cnt_ff[CH_RX]})
    else $error("receive write beyond received bytes");
  eof_stop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    fin_c[CH_TX] && st_ff[CH_TX] == ST_WBACK && cw_ff[CH_TX][CW_EOF_BIT]
    |=> st_ff[CH_TX] == ST_IDLE && tx_done ##1 !tx_done)
    else $error("chain did not stop at last descriptor");
  half_dup_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    half_duplex && $past(half_duplex) && $rose(busy_ff[CH_RX])
    |-> !busy_ff[CH_TX])
    else $error("both directions run in half-duplex");

endmodule

// ---- lldma_pkg.sv ----
// Shared constants, descriptor layout and state type for the DMA engine
package lldma_pkg;

  // ==========================================================
  // Descriptor control word layout
  localparam int CW_OWNER_BIT = 31;
  localparam int CW_EOF_BIT   = 30;
  localparam int CW_RSV_HI    = 29;
  localparam int CW_RSV_LO    = 24;
  localparam int CW_LEN_HI    = 23;
  localparam int CW_LEN_LO    = 12;
  localparam int CW_SIZE_HI   = 11;
  localparam int CW_SIZE_LO   = 0;
  localparam int FIELD_W      = 12;

  // ==========================================================
  // Chain and bus geometry
  localparam int DESC_WORDS   = 3;
  localparam int BURST_BEATS  = 4;
  localparam int CHUNK_BYTES  = 16;
  localparam int HEAD_BITS    = 20;
  localparam int WIN_KB       = 328;
  localparam int WIN_BYTES    = WIN_KB * 1024;
  localparam logic [19:0] NEXT_NULL = 20'h0_0000;
  localparam logic [3:0]  BE_ALL    = 4'hF;
  localparam logic [11:0] CNT_RST   = 12'h000;

  // ==========================================================
  // Channel indices
  localparam int NCH   = 2;
  localparam int CH_TX = 0;
  localparam int CH_RX = 1;

  // Channel states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_FETCH  = 3'h1,
    ST_CHECK  = 3'h3,
    ST_MOVE   = 3'h2,
    ST_STREAM = 3'h6,
    ST_WBACK  = 3'h7
  } lldma_st_t;

endpackage

// ---- lldma_arb.sv ----
// Round-robin arbiter granting the shared bus port to one channel
`timescale 1ns/1ps
module lldma_arb
  import lldma_pkg::*;
#(
  parameter int N = NCH
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 sys_rst,
  input  wire logic [N-1:0]                         req,
  input  wire logic                                 load,
  output logic                                      gnt_v,
  output logic [((N > 1) ? $clog2(N) : 1)-1:0]      gnt_idx
);
  localparam int IW = (N > 1) ? $clog2(N) : 1;

  logic [IW-1:0] last_ff;

  // ==========================================================
  // Elaboration check
  if (N < 2) begin : g_chk
    $error("lldma_arb needs at least two requesters");
  end

  // Search starts just after the last winner
  always_comb begin
    int idx;
    idx = 0;
    gnt_v = 1'b0;
    gnt_idx = last_ff;
    for (int k = 1; k <= N; k++) begin
      idx = (int'(last_ff) + k) % N;
      if (!gnt_v && req[idx]) begin
        gnt_v = 1'b1;
        gnt_idx = IW'(idx);
      end
    end
  end

  // Remember the winner once the bus takes it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_ff <= '0;
    end else if (load && gnt_v) begin
      last_ff <= gnt_idx;
    end
  end

endmodule

// ---- lldma_mem_model.sv ----
// Memory slave model answering the engine's bus with random waits
`timescale 1ns/1ps
module lldma_mem_model (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic [19:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [3:0]  bus_be,
  output logic             bus_ack,
  output logic [31:0]      bus_rdata
);
  logic [31:0] mem [0:4095];
  logic [31:0] junk_q;
  // Read data only with ack, otherwise a changing pattern
  assign bus_rdata = bus_ack ? mem[bus_addr[13:2]] : junk_q;
  // One ack per beat after a random wait, byte-enabled writes
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_ack <= '0;
      junk_q  <= '0;
    end else begin
      junk_q  <= ~bus_rdata;
      bus_ack <= bus_req & ~bus_ack & ($urandom_range(0, 2) == 0);
      for (int k = 0; k < 4; k++) begin
        if (bus_req && bus_ack && bus_we && bus_be[k]) begin
          mem[bus_addr[13:2]][8*k +: 8] <= bus_wdata[8*k +: 8];
        end
      end
    end
  end
endmodule

// ---- linked_list_dma_engine_tb.sv ----
// Random self-checking bench for the linked-list DMA engine
`timescale 1ns/1ps
module linked_list_dma_engine_tb;
  import lldma_pkg::*;
  logic core_clk = 0, sys_rst = 1, half_duplex = 0, tx_ready = 0;
  logic tx_chain_go_set = 0, rx_chain_go_set = 0;
  logic [19:0] tx_chain_head_pointer = '0, rx_chain_head_pointer = '0;
  logic tx_chain_go, rx_chain_go, tx_busy, rx_busy, tx_done, rx_done;
  logic desc_err, bus_req, bus_we, bus_burst4, bus_ack, tx_valid, tx_eof;
  logic [19:0] bus_addr;
  logic [31:0] bus_wdata, bus_rdata;
  logic [3:0]  bus_be;
  logic [7:0]  tx_byte, rx_byte = '0;
  logic rx_valid = 0, rx_last = 0, rx_ready, txf, rxf;
  logic [7:0] txq[$], rxq[$], rxs[$];
  logic txe[$];
  int n_errors = 0, check_count = 0;
  lldma_engine i_lldma_engine (.core_clk, .sys_rst, .half_duplex,
    .tx_chain_go_set, .rx_chain_go_set, .tx_chain_head_pointer,
    .rx_chain_head_pointer, .tx_chain_go, .rx_chain_go, .tx_busy, .rx_busy,
    .tx_done, .rx_done, .desc_err, .bus_req, .bus_we, .bus_burst4,
    .bus_addr, .bus_wdata, .bus_be, .bus_ack, .bus_rdata, .tx_byte,
    .tx_valid, .tx_eof, .tx_ready, .rx_byte, .rx_valid, .rx_last, .rx_ready);
  lldma_mem_model i_lldma_mem_model (.core_clk, .sys_rst, .bus_req, .bus_we,
    .bus_addr, .bus_wdata, .bus_be, .bus_ack, .bus_rdata);
  // ==========
  // Helpers
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task put(input logic [19:0] a, input logic [31:0] w);
    i_lldma_mem_model.mem[a[13:2]] = w;
  endtask
  function logic [7:0] gb(input logic [19:0] a);
    logic [31:0] w;
    w = i_lldma_mem_model.mem[a[13:2]];
    return w[8*a[1:0] +: 8];
  endfunction
  function logic [31:0] cw(input logic o, e, input logic [11:0] n, s);
    return {o, e, 6'h00, n, s};
  endfunction
  // ==========
  // Clock, watchdog and peripheral side
  initial forever #12.5 core_clk = ~core_clk;
  initial begin
    #2000000;
    n_errors++;
    finish_test;
  end
  always @(posedge core_clk) begin
    if (tx_valid && tx_ready) begin
      txq.push_back(tx_byte);
      txe.push_back(tx_eof);
    end
    if (rx_valid && rx_ready) void'(rxq.pop_front());
    if (tx_done) txf = 1;
    if (rx_done) rxf = 1;
    #1 tx_ready = 1'($urandom_range(0, 1));
    rx_valid = rxq.size() > 0;
    rx_byte = rx_valid ? rxq[0] : ~rx_byte;
    rx_last = rxq.size() == 1;
  end
  // ==========
  // One tx and one rx chain, optionally with a refused head descriptor
  task run(input logic hd, input logic own);
    logic [11:0] n;
    n = 12'($urandom_range(1, 16));
    half_duplex = hd;
    txq.delete();
    txe.delete();
    rxs.delete();
    txf = 0;
    rxf = 0;
    for (int i = 0; i < 5; i++) put(20'h0_1000 + 20'(4*i), $urandom);
    put(20'h0_0100, cw(own, 0, n, 12'h010));
    put(20'h0_0104, 32'h0000_1000);
    put(20'h0_0108, 32'h0000_0200);
    put(20'h0_0200, cw(1, 1, 12'h009, 12'h004));
    put(20'h0_0204, 32'h0000_1010);
    put(20'h0_0208, 32'h0000_0000);
    put(20'h0_0300, cw(1, 1, 12'h000, 12'h008));
    put(20'h0_0304, 32'h0000_3000);
    put(20'h0_0308, 32'h0000_0000);
    put(20'h0_3000, 32'ha5a5_a5a5);
    put(20'h0_3004, 32'ha5a5_a5a5);
    for (int i = 0; i < 5; i++) rxs.push_back(8'($urandom));
    rxq = rxs;
    tx_chain_head_pointer = 20'h0_0100;
    rx_chain_head_pointer = 20'h0_0300;
    tx_chain_go_set = 1;
    rx_chain_go_set = 1;
    @(posedge core_clk);
    #1 tx_chain_go_set = 0;
    rx_chain_go_set = 0;
    for (int t = 0; t < 4000 && !(txf && rxf); t++) @(posedge core_clk);
    #1 chk(txf & rxf, 1);
    chk(desc_err, !own);
    chk(get_w(20'h0_0100), cw(0, 0, n, 12'h010));
    chk(32'(txq.size()), own ? 32'(n) + 4 : 0);
    for (int i = 0; i < txq.size(); i++) begin
      chk(txq[i], i < n ? gb(20'h0_1000 + 20'(i)) : gb(20'h0_1010 + 20'(i - n)));
      chk(txe[i], i == n + 3);
    end
    if (own) chk(get_w(20'h0_0200), cw(0, 1, 12'h004, 12'h004));
    chk(get_w(20'h0_0300), cw(0, 1, 12'h005, 12'h008));
    for (int i = 0; i < 8; i++) chk(gb(20'h0_3000 + 20'(i)), i < 5 ? rxs[i] : 8'ha5);
    chk(tx_chain_go | rx_chain_go | tx_busy | rx_busy, 0);
  endtask
  function logic [31:0] get_w(input logic [19:0] a);
    return i_lldma_mem_model.mem[a[13:2]];
  endfunction
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'hb735_992e));
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 0;
    for (int r = 0; r < 6; r++) run(r[0], r != 3);
    finish_test;
  end
endmodule
